// ==== design/xcd_defs.vh ====
// timing constants and state codes for the x-capacitor discharge sequencer
// Functional notes
// R01: The mains sense level is sampled once per regulation cycle to see whether it still rises.
// R02: A rising mains level during a measurement means mains is present and keeps discharge idle.
// R03: Discharge starts only after 120 ms without any positive mains slope.
// R04: The 120 ms quiet timer starts at the detected mains peak and restarts at every new peak.
// R05: Discharge is done as separate short gate pulses, never continuous conduction.
// R06: Each pulse starts by enabling the 26 uA gate charging source so the gate rises slowly.
// R07: When current sense reaches 10 mV, charging stops and the equal sinking source turns on.
// R08: After each pulse an off-time between 1.88 ms and 6.4 ms passes before the next pulse.
// R09: Gate above 10 V while current sense is below 10 mV means full discharge and ends the run.
// R10: After full discharge the function re-arms 118 ms later unless mains returns or system stops.
// R11: Mains reconnection is recognised by a positive slope on the mains sense input.
// R12: Current sense above 50 mV during discharge terminates discharge at once.
// R13: On that termination the gate driver leaves high-impedance mode and drives the gate off.
// R14: The discharge path stays inactive in normal mains operation and engages only on mains loss.
// R15: A steady current sense offset above 10 mV disables the discharge function.
// R16: All delays are counted in device clock cycles fine enough for the millisecond limits.
// R17: Thresholds come from synchronised comparator flags so each decision uses one edge.
`ifndef XCD_DEFS_VH
`define XCD_DEFS_VH

`define XCD_CLK_MHZ         125
`define XCD_QUIET_US        120000
`define XCD_REARM_US        118000
`define XCD_OFF_US          2000
`define XCD_OFF_MIN_US      1880
`define XCD_OFF_MAX_US      6400
`define XCD_OFFSET_US       1000
`define XCD_QUIET_CYC       (`XCD_QUIET_US * `XCD_CLK_MHZ)
`define XCD_REARM_CYC       (`XCD_REARM_US * `XCD_CLK_MHZ)
`define XCD_OFF_CYC         (`XCD_OFF_US * `XCD_CLK_MHZ)
`define XCD_OFFSET_CYC      (`XCD_OFFSET_US * `XCD_CLK_MHZ)
`define XCD_CNT_W           25

`define XCD_ST_MAINS        3'h0
`define XCD_ST_CHARGE       3'h1
`define XCD_ST_SINK         3'h2
`define XCD_ST_OFF          3'h3
`define XCD_ST_DONE         3'h4
`define XCD_ST_ABORT        3'h5

`endif

// ==== design/xcd_sync2.v ====
// two-flop synchroniser for a bundle of asynchronous level inputs
module xcd_sync2 #(
	parameter W = 1
) (
	input  wire         mclk_i,
	input  wire         reset_n_i,
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// ==== design/xcd_sequencer.v ====
// x-capacitor discharge sequencer: mains slope watch, pulse engine, abort handling
`include "xcd_defs.vh"
module xcd_sequencer #(
	parameter QUIET_CYC  = `XCD_QUIET_CYC,
	parameter REARM_CYC  = `XCD_REARM_CYC,
	parameter OFF_CYC    = `XCD_OFF_CYC,
	parameter OFFSET_CYC = `XCD_OFFSET_CYC
) (
	input  wire mclk_i,
	input  wire reset_n_i,
	input  wire reg_cycle_i,
	input  wire mains_sense_input_rising_i,
	input  wire current_sense_input_10mv_i,
	input  wire current_sense_input_50mv_i,
	input  wire boost_gate_drive_10v_i,
	input  wire system_run_i,
	output reg  gate_charge_en_o,
	output reg  gate_sink_en_o,
	output reg  gate_hiz_mode_o,
	output reg  gate_drive_off_o,
	output reg  discharge_active_o,
	output reg  discharge_done_o,
	output reg  discharge_abort_o,
	output reg  discharge_disabled_o
);
	// ****************************************************************
	// input synchronisation
	// ****************************************************************
	wire       cyc_s;
	wire       rise_s;
	wire       cs10_s;
	wire       cs50_s;
	wire       g10_s;
	wire       run_s;

	xcd_sync2 #(
		.W(1)
	) u_sync_cyc (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   (reg_cycle_i),
		.sync_o    (cyc_s)
	);

	xcd_sync2 #(
		.W(1)
	) u_sync_rise (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   (mains_sense_input_rising_i), // R17
		.sync_o    (rise_s)
	);

	xcd_sync2 #(
		.W(1)
	) u_sync_cs10 (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   (current_sense_input_10mv_i), // R17
		.sync_o    (cs10_s)
	);

	xcd_sync2 #(
		.W(1)
	) u_sync_cs50 (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   (current_sense_input_50mv_i), // R17
		.sync_o    (cs50_s)
	);

	xcd_sync2 #(
		.W(1)
	) u_sync_g10 (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   (boost_gate_drive_10v_i), // R17
		.sync_o    (g10_s)
	);

	xcd_sync2 #(
		.W(1)
	) u_sync_run (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.async_i   (system_run_i),
		.sync_o    (run_s)
	);

	// ****************************************************************
	// mains slope sampling
	// ****************************************************************
	reg  cyc_prev_q;
	reg  slope_q;
	wire cyc_edge;

	assign cyc_edge = cyc_s & ~cyc_prev_q;

	// the rising flag is only trusted once per regulation cycle, so noise between
	// cycles does not reset the quiet timer
	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cyc_prev_q <= 1'b0;
			slope_q    <= 1'b0;
		end else begin
			cyc_prev_q <= cyc_s;
			slope_q    <= cyc_edge & rise_s; // R01 R11
		end
	end

	// ****************************************************************
	// current sense offset detection
	// ****************************************************************
	reg  [`XCD_CNT_W-1:0] ofs_cnt_q;
	reg  [`XCD_CNT_W-1:0] ofs_cnt_d;
	reg                   disabled_q;
	reg                   disabled_d;
	wire                  ofs_quiet;
	wire                  ofs_hit;

	// the gate sources themselves lift the sense pin, so only count while no
	// source is on; a steady offset held for the full window disables the
	// function until reset
	assign ofs_quiet = !cs10_s || gate_charge_en_o || gate_sink_en_o;
	assign ofs_hit   = (ofs_cnt_q == OFFSET_CYC[`XCD_CNT_W-1:0] - 1'b1);

	always @* begin
		ofs_cnt_d  = ofs_cnt_q;
		disabled_d = disabled_q;
		if (ofs_quiet) begin
			ofs_cnt_d = {`XCD_CNT_W{1'b0}};
		end else if (ofs_hit) begin
			disabled_d = 1'b1; // R15
		end else begin
			ofs_cnt_d = ofs_cnt_q + 1'b1;
		end
	end

	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ofs_cnt_q  <= {`XCD_CNT_W{1'b0}};
			disabled_q <= 1'b0;
		end else begin
			ofs_cnt_q  <= ofs_cnt_d;
			disabled_q <= disabled_d;
		end
	end

	// ****************************************************************
	// sequencer state codes and counter limits
	// ****************************************************************
	localparam [2:0] ST_MAINS  = `XCD_ST_MAINS;
	localparam [2:0] ST_CHARGE = `XCD_ST_CHARGE;
	localparam [2:0] ST_SINK   = `XCD_ST_SINK;
	localparam [2:0] ST_OFF    = `XCD_ST_OFF;
	localparam [2:0] ST_DONE   = `XCD_ST_DONE;
	localparam [2:0] ST_ABORT  = `XCD_ST_ABORT;

	localparam [`XCD_CNT_W-1:0] CNT_ZERO  = {`XCD_CNT_W{1'b0}};
	localparam [`XCD_CNT_W-1:0] QUIET_END = QUIET_CYC[`XCD_CNT_W-1:0] - 1'b1;
	localparam [`XCD_CNT_W-1:0] REARM_END = REARM_CYC[`XCD_CNT_W-1:0] - 1'b1;
	localparam [`XCD_CNT_W-1:0] OFF_END   = OFF_CYC[`XCD_CNT_W-1:0] - 1'b1;

	// ****************************************************************
	// sequencer
	// ****************************************************************
	reg  [2:0]            state_q;
	reg  [2:0]            state_d;
	reg  [`XCD_CNT_W-1:0] cnt_q;
	reg  [`XCD_CNT_W-1:0] cnt_d;
	wire                  quiet_hit;
	wire                  rearm_hit;
	wire                  off_hit;
	wire                  in_pulse;
	wire                  may_run;
	wire                  cut_hit;
	wire                  leave_hit;

	assign quiet_hit = (cnt_q == QUIET_END);
	assign rearm_hit = (cnt_q == REARM_END);
	assign off_hit   = (cnt_q == OFF_END);
	assign in_pulse  = (state_q == ST_CHARGE) || (state_q == ST_SINK) || (state_q == ST_OFF);
	// a sampled rise, a system stop or a late offset disable all mean that
	// discharge must not go on
	assign may_run   = !slope_q && run_s && !disabled_q;
	assign cut_hit   = in_pulse && cs50_s; // R12
	assign leave_hit = in_pulse && !may_run; // R11

	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (cut_hit) begin
			// overcurrent wins over every other event
			state_d = ST_ABORT; // R12
			cnt_d   = CNT_ZERO;
		end else if (leave_hit) begin
			state_d = ST_MAINS; // R11
			cnt_d   = CNT_ZERO;
		end else begin
			case (state_q)
				ST_MAINS: begin
					if (!may_run) begin
						cnt_d = CNT_ZERO; // R02 R04 R14
					end else if (quiet_hit) begin
						state_d = ST_CHARGE; // R03
						cnt_d   = CNT_ZERO;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				ST_CHARGE: begin
					if (g10_s && !cs10_s) begin
						state_d = ST_DONE; // R09
						cnt_d   = CNT_ZERO;
					end else if (cs10_s) begin
						state_d = ST_SINK; // R07
					end
				end
				ST_SINK: begin
					// gate ramps down until the current is gone, then off-time
					if (!cs10_s && !g10_s) begin
						state_d = ST_OFF; // R05
						cnt_d   = CNT_ZERO;
					end
				end
				ST_OFF: begin
					if (off_hit) begin
						state_d = ST_CHARGE; // R08
						cnt_d   = CNT_ZERO;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end
				ST_DONE: begin
					if (!may_run) begin
						state_d = ST_MAINS; // R10
						cnt_d   = CNT_ZERO;
					end else if (rearm_hit) begin
						state_d = ST_CHARGE; // R10
						cnt_d   = CNT_ZERO;
					end else begin
						cnt_d = cnt_q + 1'b1; // R16
					end
				end
				ST_ABORT: begin
					// hold the gate off for one cycle, then watch mains again
					state_d = ST_MAINS;
					cnt_d   = CNT_ZERO;
				end
				default: begin
					state_d = ST_MAINS;
					cnt_d   = CNT_ZERO;
				end
			endcase
		end
	end

	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= ST_MAINS;
			cnt_q   <= CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	reg  charge_d;
	reg  sink_d;
	reg  hiz_d;
	reg  drive_off_d;
	reg  active_d;
	reg  done_d;
	reg  abort_d;

	// a latched disable drops the sources at once, before the state moves on,
	// so the gate never sees a source while the function is disabled
	always @* begin
		charge_d    = (state_q == ST_CHARGE) && !disabled_q; // R06
		sink_d      = (state_q == ST_SINK) && !disabled_q; // R07
		hiz_d       = charge_d || sink_d; // R05
		drive_off_d = !hiz_d; // R13
		active_d    = in_pulse && !disabled_q; // R15
		done_d      = (state_q == ST_DONE);
		abort_d     = (state_q == ST_ABORT);
	end

	always @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gate_charge_en_o     <= 1'b0;
			gate_sink_en_o       <= 1'b0;
			gate_hiz_mode_o      <= 1'b0;
			gate_drive_off_o     <= 1'b1;
			discharge_active_o   <= 1'b0;
			discharge_done_o     <= 1'b0;
			discharge_abort_o    <= 1'b0;
			discharge_disabled_o <= 1'b0;
		end else begin
			gate_charge_en_o     <= charge_d;
			gate_sink_en_o       <= sink_d;
			gate_hiz_mode_o      <= hiz_d;
			gate_drive_off_o     <= drive_off_d;
			discharge_active_o   <= active_d;
			discharge_done_o     <= done_d;
			discharge_abort_o    <= abort_d;
			discharge_disabled_o <= disabled_q;
		end
	end
endmodule

// ==== testbench/xcd_chk.sv ====
// checker for the discharge sequencer outputs
module xcd_chk (
	input wire mclk_i,
	input wire reset_n_i,
	input wire current_sense_input_50mv_i,
	input wire system_run_i,
	input wire gate_charge_en_o,
	input wire gate_sink_en_o,
	input wire gate_hiz_mode_o,
	input wire gate_drive_off_o,
	input wire discharge_active_o,
	input wire discharge_done_o,
	input wire discharge_abort_o,
	input wire discharge_disabled_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	property p_excl; !(gate_charge_en_o && gate_sink_en_o); endproperty
	a_excl: assert property (p_excl) else $error("charge and sink together");
	property p_src;
		gate_charge_en_o || gate_sink_en_o |-> discharge_active_o && gate_hiz_mode_o;
	endproperty
	a_src: assert property (p_src) else $error("source on while idle");
	property p_hiz; gate_hiz_mode_o |-> !gate_drive_off_o; endproperty
	a_hiz: assert property (p_hiz) else $error("hiz with driver on");
	property p_start; $rose(discharge_active_o) |-> gate_charge_en_o; endproperty
	a_start: assert property (p_start) else $error("pulse not started by charge");
	property p_sink; $rose(gate_sink_en_o) |-> $fell(gate_charge_en_o); endproperty
	a_sink: assert property (p_sink) else $error("sink without charge end");
	property p_cut;
		(discharge_active_o && current_sense_input_50mv_i && system_run_i) [*3]
		|-> ##[0:3] discharge_abort_o;
	endproperty
	a_cut: assert property (p_cut) else $error("no abort on overcurrent");
	property p_pulse;
		discharge_abort_o |-> gate_drive_off_o ##1 !discharge_abort_o && !discharge_active_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("abort shape wrong");
	property p_stop;
		(!system_run_i) [*6] |-> !discharge_active_o && !discharge_done_o;
	endproperty
	a_stop: assert property (p_stop) else $error("active while stopped");
	property p_dis; discharge_disabled_o |-> !discharge_active_o; endproperty
	a_dis: assert property (p_dis) else $error("active while disabled");
	c_done: cover property (discharge_done_o);
	c_abort: cover property (discharge_abort_o);
	c_dis: cover property (discharge_disabled_o);
endmodule
bind xcd_sequencer xcd_chk u_xcd_chk (.*);

// ==== testbench/xcd_fet.sv ====
// model of the external switch with its source sense resistor
module xcd_fet (
	input  wire mclk_i,
	input  wire charge_i,
	input  wire sink_i,
	input  wire drive_off_i,
	input  wire empty_i,
	input  wire mains_back_i,
	input  wire offset_i,
	output wire cs10_o,
	output wire cs50_o,
	output wire g10_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int g = 0;
	always @(posedge mclk_i) begin
		if (drive_off_i)
			g <= 0;
		else if (charge_i)
			g <= g + 1;
		else if (sink_i && g > 0)
			g <= g - 1;
	end
	// drained caps carry no current, so the gate climbs past 10 V
	assign cs10_o = offset_i || mains_back_i || (!empty_i && g >= 8);
	assign cs50_o = mains_back_i;
	assign g10_o = g >= 30;
endmodule

// ==== testbench/xcd_sequencer_bench.sv ====
// bench: discharge sequencer against the switch model
module xcd_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 0, reset_n_i = 0, reg_cyc = 0, rising = 0, run = 0;
	logic empty = 0, back = 0, offset = 0;
	wire cs10, cs50, g10;
	wire [7:0] obs;
	int num_errors = 0, samples_checked = 0, n;
	always #4 mclk_i = ~mclk_i;
	xcd_sequencer #(.QUIET_CYC(200), .REARM_CYC(150), .OFF_CYC(20), .OFFSET_CYC(10))
	u_xcd_sequencer (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_cycle_i(reg_cyc),
		.mains_sense_input_rising_i(rising), .current_sense_input_10mv_i(cs10),
		.current_sense_input_50mv_i(cs50), .boost_gate_drive_10v_i(g10), .system_run_i(run),
		.gate_charge_en_o(obs[0]), .gate_sink_en_o(obs[1]), .gate_hiz_mode_o(obs[2]),
		.gate_drive_off_o(obs[3]), .discharge_active_o(obs[4]), .discharge_done_o(obs[5]),
		.discharge_abort_o(obs[6]), .discharge_disabled_o(obs[7]));
	xcd_fet u_xcd_fet (.mclk_i(mclk_i), .charge_i(obs[0]), .sink_i(obs[1]),
		.drive_off_i(obs[3]), .empty_i(empty), .mains_back_i(back), .offset_i(offset),
		.cs10_o(cs10), .cs50_o(cs50), .g10_o(g10));
	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask
	// bounded wait for one output bit; n returns the cycles spent
	task wt(input int b, input logic v, input int lim);
		n = 0;
		while (obs[b] !== v) begin
			cyc(1);
			n++;
			if (n > lim) begin
				chk("wait", n, lim);
				report_and_stop;
			end
		end
	endtask
	task slope;
		rising = 1;
		reg_cyc = 1;
		cyc(2);
		reg_cyc = 0;
		cyc(2);
		rising = 0;
	endtask
	task t_quiet;
		slope;
		cyc(150);
		slope;
		wt(4, 1, 300);
		chk("quiet", n >= 192 && n <= 212, 1);
		chk("start", obs[2:0], 3'h5);
		$display("quiet test end");
	endtask
	task t_pulse;
		wt(1, 1, 60);
		chk("charge end", obs[0], 1'h0);
		wt(1, 0, 60);
		chk("gap", obs[1:0], 2'h0);
		wt(0, 1, 60);
		chk("off time", n >= 18 && n <= 24, 1);
		$display("pulse test end");
	endtask
	task t_done;
		empty = 1;
		wt(5, 1, 300);
		chk("done gate", obs[1:0], 2'h0);
		wt(4, 1, 300);
		chk("rearm", n >= 145 && n <= 156, 1);
		wt(5, 1, 300);
		run = 0;
		cyc(200);
		chk("stopped", obs[5:4], 2'h0);
		run = 1;
		empty = 0;
		wt(4, 1, 300);
		$display("done test end");
	endtask
	task t_abort;
		back = 1;
		wt(6, 1, 20);
		chk("abort gate", obs[3:2], 2'h2);
		cyc(1);
		chk("abort pulse", obs[6], 1'h0);
		back = 0;
		cyc(30);
		chk("idle", obs[4], 1'h0);
		offset = 1;
		cyc(30);
		chk("disabled", obs[7], 1'h1);
		offset = 0;
		cyc(250);
		chk("no start", obs[4], 1'h0);
		$display("abort test end");
	endtask
	// mains comes back while a pulse runs: the train stops and a new quiet wait follows
	task t_reconnect;
		slope;
		cyc(3);
		chk("reconnect", obs[4], 1'h0);
		wt(4, 1, 300);
		chk("requiet", n >= 192 && n <= 212, 1);
		$display("reconnect test end");
	endtask
	// a reset in mid-run clears the sticky offset disable
	task t_reset;
		reset_n_i = 0;
		cyc(2);
		chk("reset again", obs, 8'h08);
		reset_n_i = 1;
		cyc(30);
		chk("re-enabled", obs[7], 1'h0);
		$display("reset test end");
	endtask
	initial begin
		cyc(12);
		chk("reset", obs, 8'h08);
		reset_n_i = 1;
		run = 1;
		t_quiet;
		t_pulse;
		t_done;
		t_reconnect;
		t_abort;
		t_reset;
		report_and_stop;
	end
endmodule
